// ---- pkg/aqd_pkg.sv ----
// shared constants and types for the acquisition dma block
`default_nettype none
package aqd_pkg;
	localparam int SAMPLE_W = 12;
	localparam int NUM_BANKS = 4;
	localparam int BANK_AW = 29;
	localparam logic [28:0] BANK_TOP = 29'h1fff_fffe;
	localparam logic [28:0] BANK_STEP = 29'h0000_0002;
	// register offsets (word addresses of the plain port)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DESC_ADDR = 8'h01;
	localparam logic [7:0] REG_DESC_LEN = 8'h02;
	localparam logic [7:0] REG_DESC_NEXT = 8'h03;
	localparam logic [7:0] REG_DESC_PUSH = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h05;
	localparam logic [7:0] REG_TSTAMP = 8'h06;
	localparam logic [7:0] REG_LAST_LEN = 8'h07;
	// control register field positions
	localparam int CTL_SRC_TEST = 0;
	localparam int CTL_TWO_CH = 1;
	localparam int CTL_TRANSIENT = 2;
	localparam int CTL_GATE_MODE = 3;
	localparam int CTL_META_EN = 4;
	localparam int CTL_RUN = 5;
	localparam int CTL_TTL_LO = 6;
	localparam int CTL_TTL_HI = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// function of the ttl control input
	localparam logic [1:0] TTL_GATE = 2'h0;
	localparam logic [1:0] TTL_PPS = 2'h1;
	localparam logic [1:0] TTL_SYNC = 2'h2;
	localparam int DESC_DEPTH = 16;
	localparam logic [15:0] META_TAG = 16'ha5a5;
	typedef enum logic [3:0] {
		AQD_IDLE = 4'b0001,
		AQD_META = 4'b0010,
		AQD_MOVE = 4'b0100,
		AQD_CLOSE = 4'b1000
	} aqd_dma_state_t;
endpackage : aqd_pkg
`default_nettype wire

// ---- rtl/aqd_sync3.sv ----
// three-stage pin synchroniser with agreement check
`default_nettype none
module aqd_sync3 (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	// s1 feeds only s2; a change counts once s2 and s3 agree
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
		end
	end
endmodule : aqd_sync3
`default_nettype wire

// ---- rtl/aqd_top.sv ----
// acquisition front end, bank writer and linked-list dma engine
`default_nettype none
module aqd_top
	import aqd_pkg::*;
#(
	parameter int DW = SAMPLE_W,
	parameter int DEPTH = DESC_DEPTH
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [DW-1:0] adc_ch1,
	input wire logic [DW-1:0] adc_ch2,
	input wire logic ttl_in,
	input wire logic sync_gate_in,
	input wire logic sync_reset_in,
	input wire logic ref_clk_in,
	output logic ref_clk_out,
	output logic [NUM_BANKS-1:0] bank_wr,
	output logic [BANK_AW-1:0] bank_waddr [NUM_BANKS],
	output logic [DW-1:0] bank_wdata [NUM_BANKS],
	output logic [NUM_BANKS-1:0] bank_rd,
	output logic [BANK_AW-1:0] bank_raddr [NUM_BANKS],
	input wire logic [DW-1:0] bank_rdata [NUM_BANKS],
	output logic pcie_valid,
	output logic [31:0] pcie_data,
	output logic pcie_meta,
	output logic pcie_last,
	input wire logic pcie_ready
);
	localparam int PW = $clog2(DEPTH);
	logic [31:0] ctrl_q;
	logic [31:0] dsc_addr_q;
	logic [31:0] dsc_len_q;
	logic [31:0] dsc_next_q;
	logic [31:0] d_addr [DEPTH];
	logic [31:0] d_len [DEPTH];
	logic [PW-1:0] d_next [DEPTH];
	logic [DEPTH-1:0] d_valid_q;
	logic [PW-1:0] cur_q;
	logic [31:0] tstamp_q;
	logic [31:0] start_stamp_q;
	logic [31:0] moved_q;
	logic [31:0] last_len_q;
	logic [15:0] done_cnt_q;
	logic [DW-1:0] tg_q;
	logic [1:0] rr_q;
	logic [BANK_AW-1:0] wptr_q [NUM_BANKS];
	logic [BANK_AW-1:0] rptr_q [NUM_BANKS];
	logic [NUM_BANKS-1:0] full_q;
	logic overrun_q;
	logic ttl_s;
	logic gate_s;
	logic rst_s;
	logic refc_s;
	logic ttl_prev_q;
	logic gate_act;
	logic pps_edge;
	aqd_dma_state_t st_q;
	logic [DW-1:0] src1;
	logic [DW-1:0] src2;
	logic [1:0] ttl_fn;
	logic [1:0] rd_bank;
	logic [1:0] rd_rr_q;
	logic [NUM_BANKS-1:0] have;

	// pins enter through three-stage synchronisers
	aqd_sync3 u_s_ttl (.core_clk(core_clk), .sys_rst(sys_rst),
		.pin_in(ttl_in), .level_out(ttl_s));
	aqd_sync3 u_s_gate (.core_clk(core_clk), .sys_rst(sys_rst),
		.pin_in(sync_gate_in), .level_out(gate_s));
	aqd_sync3 u_s_rst (.core_clk(core_clk), .sys_rst(sys_rst),
		.pin_in(sync_reset_in), .level_out(rst_s));
	aqd_sync3 u_s_ref (.core_clk(core_clk), .sys_rst(sys_rst),
		.pin_in(ref_clk_in), .level_out(refc_s));

	// source select and ttl function decode
	assign ttl_fn = ctrl_q[CTL_TTL_HI:CTL_TTL_LO];
	assign src1 = ctrl_q[CTL_SRC_TEST] ? tg_q : adc_ch1;
	assign src2 = ctrl_q[CTL_SRC_TEST] ? ~tg_q : adc_ch2;
	// gate is the ttl pin in gate mode, or the sync bus gate
	assign gate_act = ((ttl_fn == TTL_GATE) && ttl_s) || gate_s;
	assign pps_edge = (ttl_fn == TTL_PPS) && ttl_s && !ttl_prev_q;

	// register writes and descriptor table
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RESET;
			dsc_addr_q <= '0;
			dsc_len_q <= '0;
			dsc_next_q <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				REG_CTRL: ctrl_q <= reg_wdata;
				REG_DESC_ADDR: dsc_addr_q <= reg_wdata;
				REG_DESC_LEN: dsc_len_q <= reg_wdata;
				REG_DESC_NEXT: dsc_next_q <= reg_wdata;
				default: ;
			endcase
		end
	end

	// push stores the staged descriptor at the index in the push word
	always_ff @(posedge core_clk) begin
		if (reg_wr && reg_addr == REG_DESC_PUSH) begin
			d_addr[reg_wdata[PW-1:0]] <= dsc_addr_q;
			d_len[reg_wdata[PW-1:0]] <= dsc_len_q;
			d_next[reg_wdata[PW-1:0]] <= dsc_next_q[PW-1:0];
		end
	end

	// valid bits: set on push wins over the engine's clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			d_valid_q <= '0;
		end else begin
			if (st_q == AQD_CLOSE) begin
				d_valid_q[cur_q] <= 1'b0;
			end
			if (reg_wr && reg_addr == REG_DESC_PUSH) begin
				d_valid_q[reg_wdata[PW-1:0]] <= 1'b1;
			end
		end
	end

	// read port: data in the cycle after the strobe only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL: reg_rdata <= ctrl_q;
				REG_DESC_ADDR: reg_rdata <= dsc_addr_q;
				REG_DESC_LEN: reg_rdata <= dsc_len_q;
				REG_DESC_NEXT: reg_rdata <= dsc_next_q;
				REG_STATUS: reg_rdata <= {done_cnt_q, 4'h0, full_q,
					overrun_q, gate_act, 2'h0, st_q};
				REG_TSTAMP: reg_rdata <= tstamp_q;
				REG_LAST_LEN: reg_rdata <= last_len_q;
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// sample-accurate time stamp; pps, sync and sync-bus reset zero it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tstamp_q <= '0;
			ttl_prev_q <= 1'b0;
		end else begin
			ttl_prev_q <= ttl_s;
			if (pps_edge || rst_s || ((ttl_fn == TTL_SYNC) && ttl_s)) begin
				tstamp_q <= '0;
			end else begin
				tstamp_q <= tstamp_q + 32'h1;
			end
		end
	end

	// test signal generator: a ramp
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tg_q <= '0;
		end else begin
			tg_q <= tg_q + 1'b1;
		end
	end

	// reference clock relayed to the next board in the chain
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ref_clk_out <= 1'b0;
		end else begin
			ref_clk_out <= refc_s;
		end
	end

	// bank writer: one channel round-robin over four banks, two in pairs
	always_ff @(posedge core_clk) begin
		if (sys_rst || rst_s) begin
			rr_q <= '0;
			bank_wr <= '0;
			overrun_q <= 1'b0;
			full_q <= '0;
			for (int b = 0; b < NUM_BANKS; b++) begin
				wptr_q[b] <= '0;
				bank_waddr[b] <= '0;
				bank_wdata[b] <= '0;
			end
		end else begin
			bank_wr <= '0;
			if (ctrl_q[CTL_RUN] && gate_act) begin
				rr_q <= rr_q + 2'h1;
				for (int b = 0; b < NUM_BANKS; b++) begin
					// a bank writes when picked; each gated cycle a sample lands unless the picked bank is full in transient mode
					if ((!ctrl_q[CTL_TWO_CH] && rr_q == b[1:0]) ||
						(ctrl_q[CTL_TWO_CH] && rr_q[0] == b[0])) begin
						// transient mode stops at a full bank, fifo wraps
						if (!(ctrl_q[CTL_TRANSIENT] && full_q[b])) begin
							bank_wr[b] <= 1'b1;
							bank_waddr[b] <= wptr_q[b];
							bank_wdata[b] <= (ctrl_q[CTL_TWO_CH] && b >= 2) ?
								src2 : src1;
							wptr_q[b] <= wptr_q[b] + BANK_STEP; // two bytes a sample
							if (wptr_q[b] == BANK_TOP) begin
								full_q[b] <= 1'b1;
							end
						end
						if (!ctrl_q[CTL_TRANSIENT] && have[b] &&
							wptr_q[b] + BANK_STEP == rptr_q[b]) begin
							overrun_q <= 1'b1;
						end
					end
				end
			end
		end
	end

	// a bank has unread data when its pointers differ
	always_comb begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			have[b] = wptr_q[b] != rptr_q[b];
		end
	end
	assign rd_bank = rd_rr_q; // read order persists across descriptors

	// dma engine: meta packet, data words, close and follow link
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= AQD_IDLE;
			cur_q <= '0;
			moved_q <= '0;
			start_stamp_q <= '0;
			last_len_q <= '0;
			done_cnt_q <= '0;
			rd_rr_q <= '0;
			pcie_valid <= 1'b0;
			pcie_data <= '0;
			pcie_meta <= 1'b0;
			pcie_last <= 1'b0;
			bank_rd <= '0;
			for (int b = 0; b < NUM_BANKS; b++) begin
				rptr_q[b] <= '0;
				bank_raddr[b] <= '0;
			end
		end else begin
			bank_rd <= '0;
			if (pcie_valid && pcie_ready) begin
				pcie_valid <= 1'b0;
				pcie_meta <= 1'b0;
				pcie_last <= 1'b0;
			end
			unique case (st_q)
				AQD_IDLE: begin
					if (ctrl_q[CTL_RUN] && d_valid_q[cur_q]) begin
						moved_q <= '0;
						start_stamp_q <= tstamp_q;
						st_q <= ctrl_q[CTL_META_EN] ? AQD_META : AQD_MOVE;
					end
				end
				AQD_META: begin
					if (!pcie_valid || pcie_ready) begin
						pcie_valid <= 1'b1;
						pcie_meta <= 1'b1;
						pcie_data <= {META_TAG, d_addr[cur_q][15:0]};
						st_q <= AQD_MOVE;
					end
				end
				AQD_MOVE: begin
					// gate mode ends on gate drop once banks drain
					if ((ctrl_q[CTL_GATE_MODE] && !gate_act && have == '0) ||
						(!ctrl_q[CTL_GATE_MODE] &&
						moved_q == d_len[cur_q])) begin
						st_q <= AQD_CLOSE;
					end else if (have[rd_bank] && (!pcie_valid || pcie_ready)) begin
						bank_rd[rd_bank] <= 1'b1;
						bank_raddr[rd_bank] <= rptr_q[rd_bank];
						rptr_q[rd_bank] <= rptr_q[rd_bank] + BANK_STEP;
						pcie_valid <= 1'b1;
						pcie_data <= {20'h0, bank_rdata[rd_bank]};
						moved_q <= moved_q + 32'h1;
						rd_rr_q <= rd_rr_q + 2'h1;
					end else if (!have[rd_bank] && have != '0) begin
						rd_rr_q <= rd_rr_q + 2'h1; // skip a dry bank, no deadlock
					end
				end
				AQD_CLOSE: begin
					if (!pcie_valid || pcie_ready) begin
						// trailing word: stamp low half, length low half
						pcie_valid <= ctrl_q[CTL_META_EN];
						pcie_meta <= ctrl_q[CTL_META_EN];
						pcie_last <= ctrl_q[CTL_META_EN];
						pcie_data <= {start_stamp_q[15:0], moved_q[15:0]};
						last_len_q <= moved_q;
						done_cnt_q <= done_cnt_q + 16'h1;
						cur_q <= d_next[cur_q];
						st_q <= AQD_IDLE;
					end
				end
				default: st_q <= AQD_IDLE;
			endcase
			if (rst_s) begin // sync bus reset also rewinds the readers
				rd_rr_q <= '0;
				for (int b = 0; b < NUM_BANKS; b++) rptr_q[b] <= '0;
			end
		end
	end
endmodule : aqd_top
`default_nettype wire

// ---- dv/aqd_assertions.sv ----
// port-level assertions for the acquisition dma block
`default_nettype none
module aqd_checker
	import aqd_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [NUM_BANKS-1:0] bank_wr,
	input wire logic [BANK_AW-1:0] bank_waddr [NUM_BANKS],
	input wire logic pcie_valid,
	input wire logic [31:0] pcie_data,
	input wire logic pcie_meta,
	input wire logic pcie_last,
	input wire logic pcie_ready,
	input wire logic ref_clk_in,
	input wire logic ref_clk_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [31:0] ctl_q;
	// shadow of the control word; modes are only changed while stopped
	always_ff @(posedge core_clk) begin
		if (sys_rst) ctl_q <= CTRL_RESET;
		else if (reg_wr && reg_addr == REG_CTRL) ctl_q <= reg_wdata;
	end
	AST_ONE_CH_ONE_BANK: assert property (
		!ctl_q[CTL_TWO_CH] |-> $onehot0(bank_wr))
		else $error("one-channel mode wrote two banks");
	AST_TWO_CH_PAIRS: assert property (
		ctl_q[CTL_TWO_CH] |-> (|bank_wr[1:0]) == (|bank_wr[3:2])
		&& $onehot0(bank_wr[1:0]) && $onehot0(bank_wr[3:2]))
		else $error("two-channel bank pairing broken");
	AST_BANK_SPAN: assert property (
		bank_wr[0] |-> bank_waddr[0] <= BANK_TOP && !bank_waddr[0][0])
		else $error("bank address outside its space");
	AST_HOLD_UNTIL_READY: assert property (
		pcie_valid && !pcie_ready |=> pcie_valid && $stable(pcie_data)
		&& $stable(pcie_last))
		else $error("dma word dropped before ready");
	AST_META_TAG: assert property (
		pcie_valid && pcie_meta && !pcie_last |-> pcie_data[31:16] == META_TAG)
		else $error("metadata word lacks its tag");
	AST_CLOSE_WORD: assert property (
		pcie_last |-> pcie_valid && (pcie_meta || !ctl_q[CTL_META_EN]))
		else $error("closing word malformed");
	AST_WRITE_NEEDS_RUN: assert property (
		|bank_wr |-> ctl_q[CTL_RUN] || $past(ctl_q[CTL_RUN]))
		else $error("bank written while stopped");
	AST_REF_FOLLOWS: assert property (
		$rose(ref_clk_out) |-> $past(ref_clk_in, 2))
		else $error("reference clock out rose without input");
	cover property (pcie_valid && pcie_ready && pcie_last);
	cover property (pcie_valid && !pcie_ready);
	cover property (ctl_q[CTL_TWO_CH] && |bank_wr[3:2]);
endmodule : aqd_checker
`default_nettype wire

// ---- dv/aqd_host_model.sv ----
// host-side dma sink that can stall
`default_nettype none
module aqd_host_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic pcie_valid,
	input wire logic [31:0] pcie_data,
	input wire logic pcie_meta,
	input wire logic pcie_last,
	output logic pcie_ready,
	output int n_words,
	output int n_last,
	output logic [31:0] first_w,
	output logic [31:0] last_w
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_q;
	// slow mode accepts one cycle in four so holds get exercised
	always_ff @(posedge core_clk) begin
		ph_q <= sys_rst ? 2'h0 : ph_q + 2'h1;
		if (sys_rst) begin
			n_words <= 0;
			n_last <= 0;
		end else if (pcie_valid && pcie_ready) begin
			if (pcie_meta && !pcie_last) first_w <= pcie_data;
			if (pcie_last) last_w <= pcie_data;
			n_last <= n_last + int'(pcie_last);
			n_words <= n_words + 1;
		end
	end
	assign pcie_ready = !slow || ph_q == 2'h3;
endmodule : aqd_host_model
`default_nettype wire

// ---- dv/aqd_top_tb_top.sv ----
// self-checking bench for the acquisition dma block
`default_nettype none
module aqd_top_tb_top;
	import aqd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic slow = 1'b0, ttl_in = 1'b0, sync_gate_in = 1'b0;
	logic sync_reset_in = 1'b0, ref_clk_in = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, pcie_data, fw, lw, v;
	logic [11:0] adc_ch1 = 12'h0, adc_ch2 = 12'h0;
	logic [11:0] bank_wdata [4], bank_rdata [4], wl [4];
	logic [28:0] bank_waddr [4], bank_raddr [4];
	logic [3:0] bank_wr, bank_rd;
	logic [2:0] rc_q = 3'h0;
	logic ref_clk_out, pcie_valid, pcie_meta, pcie_last, pcie_ready;
	int n_errors = 0, compares = 0, nw, nl, wcyc, wc [4];
	aqd_top i_dut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .adc_ch1, .adc_ch2, .ttl_in, .sync_gate_in,
		.sync_reset_in, .ref_clk_in, .ref_clk_out, .bank_wr, .bank_waddr,
		.bank_wdata, .bank_rd, .bank_raddr, .bank_rdata, .pcie_valid,
		.pcie_data, .pcie_meta, .pcie_last, .pcie_ready);
	aqd_host_model i_host (.core_clk, .sys_rst, .slow, .pcie_valid,
		.pcie_data, .pcie_meta, .pcie_last, .pcie_ready, .n_words(nw),
		.n_last(nl), .first_w(fw), .last_w(lw));
	always #12.5 core_clk = !core_clk;
	// memory answers with a pattern tied to the read address
	always_comb for (int i = 0; i < 4; i++) bank_rdata[i] = ~bank_raddr[i][11:0];
	// slow reference clock and a tally of bank writes
	always @(posedge core_clk) begin
		rc_q <= rc_q + 3'h1;
		if (rc_q == 3'h7) ref_clk_in <= !ref_clk_in;
		if (|bank_wr) wcyc++;
		for (int i = 0; i < 4; i++) if (bank_wr[i]) begin
			wc[i]++;
			wl[i] = bank_wdata[i];
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge core_clk);
	endtask : rd
	// one gate of n cycles; the pipeline drains before stopping
	task automatic cap(input logic [31:0] c, input int n, input bit ttl);
		wcyc = 0;
		wc = '{default: 0};
		wr(REG_CTRL, c);
		if (ttl) ttl_in <= 1'b1;
		else sync_gate_in <= 1'b1;
		repeat (n) @(posedge core_clk);
		ttl_in <= 1'b0;
		sync_gate_in <= 1'b0;
		repeat (10) @(posedge core_clk);
		wr(REG_CTRL, 32'h0);
	endtask : cap
	task automatic push(input logic [31:0] a, input logic [31:0] l);
		wr(REG_DESC_ADDR, a);
		wr(REG_DESC_LEN, l);
		wr(REG_DESC_NEXT, 32'h0);
		wr(REG_DESC_PUSH, 32'h0);
	endtask : push
	task automatic wait_last(input int t);
		for (int k = 0; k < 800 && nl < t; k++) @(posedge core_clk);
		chk(nl, t);
	endtask : wait_last
	task automatic t_regs;
		rd(REG_CTRL, v);
		chk(v, CTRL_RESET);
		for (int k = 0; k < 3; k++) begin
			wr(REG_CTRL, 32'(k) << CTL_TTL_LO);
			rd(REG_CTRL, v);
			chk(v, 32'(k) << CTL_TTL_LO);
		end
		rd(8'h3f, v);
		chk(v, 32'h0);
	endtask : t_regs
	task automatic t_one;
		adc_ch1 <= 12'h5a3;
		cap(32'h20, 20, 1'b1);
		chk(wcyc, 20);
		for (int i = 0; i < 4; i++) chk(wc[i], 5);
		chk(wl[0], 12'h5a3);
		cap(32'h60, 6, 1'b1);
		chk(wcyc, 0);
	endtask : t_one
	task automatic t_two;
		adc_ch1 <= 12'h111;
		adc_ch2 <= 12'h222;
		cap(32'h22, 10, 1'b0);
		chk(wcyc, 10);
		for (int i = 0; i < 4; i++) chk(wc[i], 5);
		for (int i = 0; i < 4; i++) chk(wl[i], i < 2 ? 12'h111 : 12'h222);
		cap(32'h27, 4, 1'b0);
		chk(wcyc, 4);
		chk(wl[0] !== 12'h111, 1);
		chk(wl[2], 12'(~wl[0]));
		chk(wl[1], 12'(wl[0] + 12'h1));
	endtask : t_two
	task automatic t_dma;
		push(32'h1234, 32'h4);
		slow <= 1'b1;
		wr(REG_CTRL, 32'h30);
		wait_last(1);
		chk(fw, {META_TAG, 16'h1234});
		chk(lw[15:0], 16'h4);
		rd(REG_LAST_LEN, v);
		chk(v, 32'h4);
		rd(REG_STATUS, v);
		chk(v[31:16], 16'h1);
		wr(REG_CTRL, 32'h0);
	endtask : t_dma
	task automatic t_gate;
		push(32'h42, 32'h0);
		wr(REG_CTRL, 32'h18);
		sync_gate_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		wr(REG_CTRL, 32'h38);
		repeat (8) @(posedge core_clk);
		sync_gate_in <= 1'b0;
		wait_last(2);
		rd(REG_STATUS, v);
		chk(v[31:16], 16'h2);
		chk(v[3:0], AQD_IDLE);
		rd(REG_LAST_LEN, v);
		chk(v == 32'h0, 1'b0);
		sync_reset_in <= 1'b1;
		repeat (8) @(posedge core_clk);
		sync_reset_in <= 1'b0;
		rd(REG_TSTAMP, v);
		chk(v, 32'h0);
	endtask : t_gate
	task automatic end_sim;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	initial begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_regs;
		t_one;
		t_two;
		t_dma;
		t_gate;
		end_sim;
	end
	// the whole run needs well under a third of this span
	initial begin
		#100us;
		n_errors++;
		end_sim;
	end
endmodule : aqd_top_tb_top
bind aqd_top aqd_checker i_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
	.reg_wr, .bank_wr, .bank_waddr, .pcie_valid, .pcie_data, .pcie_meta,
	.pcie_last, .pcie_ready, .ref_clk_in, .ref_clk_out);
`default_nettype wire
